// *** logic/mdp_regs.svh ***
/*
  Constants of the compare / multiply / divide datapath: cycle counts per
  operation, source and outcome, and the condition flag bit positions.
  Assumes it is included by bare name from the datapath.
*/
// Notes on behaviour
// - Accumulator byte divide takes 3 cycles zero, 7 overflow, 15 normal.
// - Register byte divide takes 4 cycles zero, 8 overflow, 16 normal.
// - Memory byte divide takes 6, 9 or 19 cycles plus addressing correction.
// - Register word divide takes 4 cycles zero, 7 overflow, 22 normal.
// - Memory word divide takes 6, 8 or 26 cycles plus addressing correction.
// - Accumulator byte multiply takes 3 cycles if high byte zero, else 7.
// - Register byte multiply takes 4 cycles if register byte zero, else 8.
// - Memory byte multiply takes 5 or 9 cycles plus correction.
// - Accumulator word multiply takes 3 cycles if high word zero, else 11.
// - Register word multiply takes 4 cycles if register word zero, else 12.
// - Memory word multiply takes 5 or 13 cycles plus correction.
// - Accumulator byte divide: high word by low byte, quotient low, remainder high.
// - Signed register byte divide: quotient to accumulator, remainder to register.
// - Signed register word divide: long accumulator by word, same placement.
// - Long compare with immediate completes in 3 cycles, flags only.
// - Signed divide overflow may spoil the low accumulator; nothing relies on it.
`ifndef MDP_REGS_SVH
`define MDP_REGS_SVH

// ----------------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------------
`define MDP_FLAG_N 3
`define MDP_FLAG_Z 2
`define MDP_FLAG_V 1
`define MDP_FLAG_C 0
`define MDP_FLAGS_VC 4'h3
`define MDP_FLAGS_ALL 4'hf

// ----------------------------------------------------------------------
// Cycle counts: zero / overflow / normal
// ----------------------------------------------------------------------
`define MDP_UDB_ACC_Z 8'd3
`define MDP_UDB_ACC_O 8'd7
`define MDP_UDB_ACC_N 8'd15
`define MDP_UDB_REG_Z 8'd4
`define MDP_UDB_REG_O 8'd8
`define MDP_UDB_REG_N 8'd16
`define MDP_UDB_MEM_Z 8'd6
`define MDP_UDB_MEM_O 8'd9
`define MDP_UDB_MEM_N 8'd19
`define MDP_UDW_REG_Z 8'd4
`define MDP_UDW_REG_O 8'd7
`define MDP_UDW_REG_N 8'd22
`define MDP_UDW_MEM_Z 8'd6
`define MDP_UDW_MEM_O 8'd8
`define MDP_UDW_MEM_N 8'd26
// Multiply: zero operand / nonzero operand
`define MDP_UMB_ACC_Z 8'd3
`define MDP_UMB_ACC_N 8'd7
`define MDP_UMB_REG_Z 8'd4
`define MDP_UMB_REG_N 8'd8
`define MDP_UMB_MEM_Z 8'd5
`define MDP_UMB_MEM_N 8'd9
`define MDP_UMW_ACC_Z 8'd3
`define MDP_UMW_ACC_N 8'd11
`define MDP_UMW_REG_Z 8'd4
`define MDP_UMW_REG_N 8'd12
`define MDP_UMW_MEM_Z 8'd5
`define MDP_UMW_MEM_N 8'd13
// Compare: byte and word share counts, long differs
`define MDP_CPR_ACC 8'd1
`define MDP_CPR_REG 8'd2
`define MDP_CPR_MEM 8'd3
`define MDP_CPR_IMM 8'd2
`define MDP_CPRL_REG 8'd6
`define MDP_CPRL_MEM 8'd7
`define MDP_CPRL_IMM 8'd3

`endif

// *** logic/mdp_pkg.sv ***
/*
  Types of the compare / multiply / divide datapath.
  Assumes mdp_regs.svh is on the include path.
*/
package mdp_pkg;
  typedef enum logic [3:0] {
    OP_COMPARE_BYTE           = 4'h0,
    OP_COMPARE_WORD           = 4'h1,
    OP_COMPARE_LONG           = 4'h2,
    OP_UNSIGNED_DIVIDE_BYTE   = 4'h3,
    OP_UNSIGNED_DIVIDE_WORD   = 4'h4,
    OP_SIGNED_DIVIDE_BYTE     = 4'h5,
    OP_SIGNED_DIVIDE_WORD     = 4'h6,
    OP_UNSIGNED_MULTIPLY_BYTE = 4'h7,
    OP_UNSIGNED_MULTIPLY_WORD = 4'h8
  } mdp_op_t;

  typedef enum logic [1:0] {
    SRC_ACC = 2'h0,
    SRC_REG = 2'h1,
    SRC_MEM = 2'h2,
    SRC_IMM = 2'h3
  } mdp_src_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } mdp_st_t;

  typedef struct packed {
    mdp_st_t     st;
    logic        busy;
    logic        done;
    logic [7:0]  cnt;
    logic [31:0] acc;
    logic [31:0] res;
    logic [3:0]  flags;
    logic        acc_wp;
    logic        res_wp;
    logic [3:0]  flag_wp;
    logic        acc_we;
    logic        res_we;
    logic [3:0]  flag_we;
  } mdp_state_t;
endpackage : mdp_pkg

// *** logic/mdp_datapath.sv ***
/*
  Compare, unsigned multiply and signed/unsigned divide datapath with
  operand-dependent execution time.
  Assumes the sequencer supplies operands and addressing corrections with a
  one-cycle START while BUSY is low, and performs the write-backs itself.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mdp_regs.svh"

module mdp_datapath
  import mdp_pkg::*;
#(
  parameter int CORR_W = 4
) (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              CE,
  input  wire logic              START,
  input  wire mdp_op_t           OP,
  input  wire mdp_src_t          SRC,
  input  wire logic [31:0]       ACC_IN,
  input  wire logic [31:0]       OPND_IN,
  input  wire logic [CORR_W-1:0] CORR_A,
  input  wire logic [CORR_W-1:0] CORR_B,
  output logic                   BUSY,
  output logic                   DONE,
  output logic [31:0]            ACC_OUT,
  output logic                   ACC_WE,
  output logic [31:0]            RES_OUT,
  output logic                   RES_WE,
  output logic [3:0]             FLAGS,
  output logic [3:0]             FLAG_WE
);

  // ----------------------------------------------------------------------
  // Cycle count selection
  // ----------------------------------------------------------------------
  function automatic logic [7:0] base_cycles(input mdp_op_t op, input mdp_src_t src,
                                             input logic zero, input logic ovf);
    logic [1:0] k;
    k = {src == SRC_MEM, src == SRC_ACC};
    base_cycles = 8'd1;
    unique case (op)
      OP_COMPARE_BYTE, OP_COMPARE_WORD: begin
        unique case (src)
          SRC_ACC: base_cycles = `MDP_CPR_ACC;
          SRC_REG: base_cycles = `MDP_CPR_REG;
          SRC_MEM: base_cycles = `MDP_CPR_MEM;
          SRC_IMM: base_cycles = `MDP_CPR_IMM;
        endcase
      end
      OP_COMPARE_LONG: begin
        unique case (src)
          SRC_MEM: base_cycles = `MDP_CPRL_MEM;
          SRC_IMM: base_cycles = `MDP_CPRL_IMM;
          default: base_cycles = `MDP_CPRL_REG;
        endcase
      end
      OP_UNSIGNED_DIVIDE_BYTE, OP_SIGNED_DIVIDE_BYTE: begin
        unique case (k)
          2'b01:   base_cycles = zero ? `MDP_UDB_ACC_Z : ovf ? `MDP_UDB_ACC_O
                                                        : `MDP_UDB_ACC_N;
          2'b10:   base_cycles = zero ? `MDP_UDB_MEM_Z : ovf ? `MDP_UDB_MEM_O
                                                        : `MDP_UDB_MEM_N;
          default: base_cycles = zero ? `MDP_UDB_REG_Z : ovf ? `MDP_UDB_REG_O
                                                        : `MDP_UDB_REG_N;
        endcase
      end
      OP_UNSIGNED_DIVIDE_WORD, OP_SIGNED_DIVIDE_WORD: begin
        if (src == SRC_MEM) begin
          base_cycles = zero ? `MDP_UDW_MEM_Z : ovf ? `MDP_UDW_MEM_O
                                               : `MDP_UDW_MEM_N;
        end else begin
          base_cycles = zero ? `MDP_UDW_REG_Z : ovf ? `MDP_UDW_REG_O
                                               : `MDP_UDW_REG_N;
        end
      end
      OP_UNSIGNED_MULTIPLY_BYTE: begin
        unique case (k)
          2'b01:   base_cycles = zero ? `MDP_UMB_ACC_Z : `MDP_UMB_ACC_N;
          2'b10:   base_cycles = zero ? `MDP_UMB_MEM_Z : `MDP_UMB_MEM_N;
          default: base_cycles = zero ? `MDP_UMB_REG_Z : `MDP_UMB_REG_N;
        endcase
      end
      OP_UNSIGNED_MULTIPLY_WORD: begin
        unique case (k)
          2'b01:   base_cycles = zero ? `MDP_UMW_ACC_Z : `MDP_UMW_ACC_N;
          2'b10:   base_cycles = zero ? `MDP_UMW_MEM_Z : `MDP_UMW_MEM_N;
          default: base_cycles = zero ? `MDP_UMW_REG_Z : `MDP_UMW_REG_N;
        endcase
      end
      default: base_cycles = 8'd1;
    endcase
  endfunction : base_cycles

  function automatic logic is_div(input mdp_op_t op);
    is_div = (op == OP_UNSIGNED_DIVIDE_BYTE) || (op == OP_UNSIGNED_DIVIDE_WORD) ||
             (op == OP_SIGNED_DIVIDE_BYTE) || (op == OP_SIGNED_DIVIDE_WORD);
  endfunction : is_div

  function automatic logic is_mul(input mdp_op_t op);
    is_mul = (op == OP_UNSIGNED_MULTIPLY_BYTE) || (op == OP_UNSIGNED_MULTIPLY_WORD);
  endfunction : is_mul

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  mdp_state_t s_q;
  mdp_state_t s_d;
  logic       go;

  assign go = START && !s_q.busy;

  always_comb begin
    logic        byte_op;
    logic        sgn;
    logic        zero;
    logic        ovf;
    logic [31:0] dvd;
    logic [31:0] dvs;
    logic [31:0] q;
    logic [31:0] r;
    logic [31:0] sq;
    logic [31:0] ca;
    logic [31:0] cb;
    logic [32:0] diff;
    logic [7:0]  n;
    byte_op = 1'b0;
    sgn     = 1'b0;
    zero    = 1'b0;
    ovf     = 1'b0;
    dvd     = 32'h0;
    dvs     = 32'h0;
    q       = 32'h0;
    r       = 32'h0;
    sq      = 32'h0;
    ca      = 32'h0;
    cb      = 32'h0;
    diff    = 33'h0;
    n       = 8'h0;
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.acc_we  = 1'b0;
    s_d.res_we  = 1'b0;
    s_d.flag_we = 4'h0;
    unique case (s_q.st)
      ST_IDLE: begin
        if (go) begin
          byte_op = (OP == OP_UNSIGNED_DIVIDE_BYTE) || (OP == OP_SIGNED_DIVIDE_BYTE);
          sgn     = (OP == OP_SIGNED_DIVIDE_BYTE) || (OP == OP_SIGNED_DIVIDE_WORD);
          s_d.acc     = ACC_IN;
          s_d.acc_wp  = 1'b0;
          s_d.res_wp  = 1'b0;
          s_d.flag_wp = 4'h0;
          if (is_div(OP)) begin
            // Accumulator form: high word by low byte
            if (byte_op && SRC == SRC_ACC) begin
              dvd = {16'h0, ACC_IN[31:16]};
              dvs = {24'h0, ACC_IN[7:0]};
            end else if (byte_op) begin
              dvd = {16'h0, ACC_IN[15:0]};
              dvs = {24'h0, OPND_IN[7:0]};
            end else begin
              dvd = ACC_IN;
              dvs = {16'h0, OPND_IN[15:0]};
            end
            if (sgn) begin
              dvd = byte_op ? {{16{dvd[15]}}, dvd[15:0]} : dvd;
              dvs = byte_op ? {{24{dvs[7]}}, dvs[7:0]} : {{16{dvs[15]}}, dvs[15:0]};
            end
            zero = (dvs == 32'h0);
            if (!zero) begin
              if (sgn) begin
                sq = 32'($signed(dvd) / $signed(dvs));
                r  = 32'($signed(dvd) % $signed(dvs));
                q  = sq;
                ovf = byte_op ? (sq != {{24{sq[7]}}, sq[7:0]})
                              : (sq != {{16{sq[15]}}, sq[15:0]});
              end else begin
                q   = dvd / dvs;
                r   = dvd % dvs;
                ovf = byte_op ? (q[31:8] != 24'h0) : (q[31:16] != 16'h0);
              end
            end
            // Only the V and C flags are written back on overflow or zero divisor, which
            // also keeps the low accumulator intact where it may be spoilt.
            if (!zero && !ovf) begin
              s_d.acc_wp = 1'b1;
              if (byte_op && SRC == SRC_ACC) begin
                s_d.acc[7:0]   = q[7:0];
                s_d.acc[23:16] = r[7:0];
              end else if (byte_op) begin
                s_d.acc[7:0] = q[7:0];
                s_d.res      = {24'h0, r[7:0]};
                s_d.res_wp   = 1'b1;
              end else begin
                s_d.acc[15:0] = q[15:0];
                s_d.res       = {16'h0, r[15:0]};
                s_d.res_wp    = 1'b1;
              end
            end
            s_d.flags[`MDP_FLAG_V] = zero | ovf;
            s_d.flags[`MDP_FLAG_C] = zero;
            s_d.flag_wp = `MDP_FLAGS_VC;
          end else if (is_mul(OP)) begin
            s_d.acc_wp = 1'b1;
            if (OP == OP_UNSIGNED_MULTIPLY_BYTE) begin
              dvs  = SRC == SRC_ACC ? {24'h0, ACC_IN[23:16]} : {24'h0, OPND_IN[7:0]};
              zero = dvs[7:0] == 8'h0;
              s_d.acc[15:0] = 16'(ACC_IN[7:0] * dvs[7:0]);
            end else begin
              dvs  = SRC == SRC_ACC ? {16'h0, ACC_IN[31:16]} : {16'h0, OPND_IN[15:0]};
              zero = dvs[15:0] == 16'h0;
              s_d.acc = 32'(ACC_IN[15:0] * dvs[15:0]);
            end
          end else begin
            // Operands left-aligned so one subtractor serves all widths
            unique case (OP)
              OP_COMPARE_BYTE: begin
                ca = SRC == SRC_ACC ? {ACC_IN[23:16], 24'h0} : {ACC_IN[7:0], 24'h0};
                cb = SRC == SRC_ACC ? {ACC_IN[7:0], 24'h0} : {OPND_IN[7:0], 24'h0};
              end
              OP_COMPARE_WORD: begin
                ca = SRC == SRC_ACC ? {ACC_IN[31:16], 16'h0} : {ACC_IN[15:0], 16'h0};
                cb = SRC == SRC_ACC ? {ACC_IN[15:0], 16'h0} : {OPND_IN[15:0], 16'h0};
              end
              default: begin
                ca = ACC_IN;
                cb = OPND_IN;
              end
            endcase
            diff = {1'b0, ca} - {1'b0, cb};
            s_d.flags[`MDP_FLAG_N] = diff[31];
            s_d.flags[`MDP_FLAG_Z] = diff[31:0] == 32'h0;
            s_d.flags[`MDP_FLAG_V] = (ca[31] ^ cb[31]) & (ca[31] ^ diff[31]);
            s_d.flags[`MDP_FLAG_C] = diff[32];
            s_d.flag_wp = `MDP_FLAGS_ALL;
          end
          n = base_cycles(OP, SRC, zero, ovf);
          if (SRC == SRC_MEM) begin
            n = n + 8'(CORR_A) + 8'(CORR_B);
            if (is_div(OP) && !zero && !ovf) begin
              n = n + 8'(CORR_B);
            end
          end
          s_d.cnt  = n - 8'd1;
          s_d.st   = ST_RUN;
          s_d.busy = 1'b1;
        end
      end
      ST_RUN: begin
        if (s_q.cnt == 8'h0) begin
          s_d.st      = ST_IDLE;
          s_d.busy    = 1'b0;
          s_d.done    = 1'b1;
          s_d.acc_we  = s_q.acc_wp;
          s_d.res_we  = s_q.res_wp;
          s_d.flag_we = s_q.flag_wp;
        end else begin
          s_d.cnt = s_q.cnt - 8'd1;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign BUSY    = s_q.busy;
  assign DONE    = s_q.done;
  assign ACC_OUT = s_q.acc;
  assign ACC_WE  = s_q.acc_we;
  assign RES_OUT = s_q.res;
  assign RES_WE  = s_q.res_we;
  assign FLAGS   = s_q.flags;
  assign FLAG_WE = s_q.flag_we;

  // ----------------------------------------------------------------------
  // Checks (CE held high during the measured span)
  // ----------------------------------------------------------------------
  property p_udb_acc_zero;
    @(posedge CLK) disable iff (SYS_RST || !CE)
    go && OP == OP_UNSIGNED_DIVIDE_BYTE && SRC == SRC_ACC && ACC_IN[7:0] == 8'h0
    |=> !DONE ##1 !DONE ##1 !DONE ##1 DONE;
  endproperty
  a_udb_acc_zero: assert property (p_udb_acc_zero) else $error("byte divide zero time");

  property p_udb_reg_norm;
    @(posedge CLK) disable iff (SYS_RST || !CE)
    go && OP == OP_UNSIGNED_DIVIDE_BYTE && SRC == SRC_REG && OPND_IN[7:0] == 8'h10 &&
    ACC_IN[15:12] == 4'h0
    |-> ##17 DONE && ACC_WE && RES_WE;
  endproperty
  a_udb_reg_norm: assert property (p_udb_reg_norm) else $error("byte divide time");

  property p_udb_mem_zero;
    @(posedge CLK) disable iff (SYS_RST || !CE)
    go && OP == OP_UNSIGNED_DIVIDE_BYTE && SRC == SRC_MEM && OPND_IN[7:0] == 8'h0 &&
    CORR_A == CORR_W'(2) && CORR_B == CORR_W'(3)
    |-> ##12 DONE;
  endproperty
  a_udb_mem_zero: assert property (p_udb_mem_zero) else $error("mem divide time");

  property p_udw_reg_zero;
    @(posedge CLK) disable iff (SYS_RST || !CE)
    go && OP == OP_UNSIGNED_DIVIDE_WORD && SRC == SRC_REG && OPND_IN[15:0] == 16'h0
    |-> ##5 DONE && !ACC_WE && FLAGS[`MDP_FLAG_V];
  endproperty
  a_udw_reg_zero: assert property (p_udw_reg_zero) else $error("word divide zero");

  property p_umb_acc_norm;
    @(posedge CLK) disable iff (SYS_RST || !CE)
    go && OP == OP_UNSIGNED_MULTIPLY_BYTE && SRC == SRC_ACC && ACC_IN[23:16] != 8'h0
    |-> ##8 DONE;
  endproperty
  a_umb_acc_norm: assert property (p_umb_acc_norm) else $error("byte multiply time");

  property p_umw_reg_norm;
    @(posedge CLK) disable iff (SYS_RST || !CE)
    go && OP == OP_UNSIGNED_MULTIPLY_WORD && SRC == SRC_REG && OPND_IN[15:0] != 16'h0
    |-> ##13 DONE;
  endproperty
  a_umw_reg_norm: assert property (p_umw_reg_norm) else $error("word multiply time");

  property p_cpr_long_imm;
    @(posedge CLK) disable iff (SYS_RST || !CE)
    go && OP == OP_COMPARE_LONG && SRC == SRC_IMM
    |=> BUSY ##1 BUSY ##1 BUSY ##1 DONE && !BUSY && FLAG_WE == `MDP_FLAGS_ALL;
  endproperty
  a_cpr_long_imm: assert property (p_cpr_long_imm) else $error("long compare time");

  property p_cpr_no_write;
    @(posedge CLK) disable iff (SYS_RST)
    DONE && $past(s_q.flag_wp) == `MDP_FLAGS_ALL |-> !ACC_WE && !RES_WE;
  endproperty
  a_cpr_no_write: assert property (p_cpr_no_write) else $error("compare wrote data");

  property p_flag_scope;
    @(posedge CLK) disable iff (SYS_RST)
    DONE |-> FLAG_WE inside {4'h0, `MDP_FLAGS_VC, `MDP_FLAGS_ALL} && BUSY == 1'b0;
  endproperty
  a_flag_scope: assert property (p_flag_scope) else $error("flag mask wrong");

endmodule : mdp_datapath

`default_nettype wire

// *** verification/tb_top.sv ***
/*
  Self-checking bench of the compare / multiply / divide datapath.
  Assumes mdp_pkg is compiled first and mdp_regs.svh is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import mdp_pkg::*;
;
  logic        CLK;
  logic        SYS_RST;
  logic        CE;
  logic        START;
  mdp_op_t     OP;
  mdp_src_t    SRC;
  logic [31:0] ACC_IN;
  logic [31:0] OPND_IN;
  logic [3:0]  CORR_A;
  logic [3:0]  CORR_B;
  logic        BUSY;
  logic        DONE;
  logic [31:0] ACC_OUT;
  logic        ACC_WE;
  logic [31:0] RES_OUT;
  logic        RES_WE;
  logic [3:0]  FLAGS;
  logic [3:0]  FLAG_WE;
  int          failures;
  int          tests_run;
  int          cyc;
  int          ticks;

  mdp_datapath #(.CORR_W(4)) mdp_datapath_inst (
    .CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .START(START), .OP(OP), .SRC(SRC),
    .ACC_IN(ACC_IN), .OPND_IN(OPND_IN), .CORR_A(CORR_A), .CORR_B(CORR_B),
    .BUSY(BUSY), .DONE(DONE), .ACC_OUT(ACC_OUT), .ACC_WE(ACC_WE),
    .RES_OUT(RES_OUT), .RES_WE(RES_WE), .FLAGS(FLAGS), .FLAG_WE(FLAG_WE)
  );

  // ----------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------
  always #2.5 CLK = ~CLK;

  // The whole run needs well under 2000 cycles
  always @(posedge CLK) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  // Issues one request and counts clock edges up to the completion pulse
  task automatic run_op(input mdp_op_t op, input mdp_src_t src, input logic [31:0] acc,
                        input logic [31:0] opnd, input logic [3:0] ca, input logic [3:0] cb);
    @(posedge CLK);
    OP      <= op;
    SRC     <= src;
    ACC_IN  <= acc;
    OPND_IN <= opnd;
    CORR_A  <= ca;
    CORR_B  <= cb;
    START   <= 1'b1;
    @(posedge CLK);
    START <= 1'b0;
    cyc = 0;
    do begin
      @(posedge CLK);
      #1;
      cyc++;
    end while (DONE !== 1'b1 && cyc < 64);
  endtask : run_op

  // Timing and write strobes of the last operation
  task automatic ck_run(input int n, input logic [3:0] fwe, input logic awe, input logic rwe);
    chk(cyc == n, "cycle count");
    chk(FLAG_WE === fwe && ACC_WE === awe && RES_WE === rwe, "write strobes");
  endtask : ck_run

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_udiv_byte_acc;
    run_op(OP_UNSIGNED_DIVIDE_BYTE, SRC_ACC, 32'h0123_0000, 32'h0, 4'h0, 4'h0);
    ck_run(3, 4'h3, 1'b0, 1'b0);
    chk(FLAGS[1:0] === 2'b11, "zero divisor flags");
    run_op(OP_UNSIGNED_DIVIDE_BYTE, SRC_ACC, 32'h1000_0002, 32'h0, 4'h0, 4'h0);
    ck_run(7, 4'h3, 1'b0, 1'b0);
    chk(FLAGS[1:0] === 2'b10, "overflow flags");
    run_op(OP_UNSIGNED_DIVIDE_BYTE, SRC_ACC, 32'h0123_0010, 32'h0, 4'h0, 4'h0);
    ck_run(15, 4'h3, 1'b1, 1'b0);
    chk(ACC_OUT[7:0] === 8'h12 && ACC_OUT[23:16] === 8'h03, "quotient placement");
    chk(FLAGS[1:0] === 2'b00, "normal flags");
  endtask : t_udiv_byte_acc

  task automatic t_udiv_byte_ext;
    run_op(OP_UNSIGNED_DIVIDE_BYTE, SRC_REG, 32'h0000_0123, 32'h0, 4'h0, 4'h0);
    ck_run(4, 4'h3, 1'b0, 1'b0);
    run_op(OP_UNSIGNED_DIVIDE_BYTE, SRC_REG, 32'h0000_1000, 32'h02, 4'h0, 4'h0);
    ck_run(8, 4'h3, 1'b0, 1'b0);
    run_op(OP_UNSIGNED_DIVIDE_BYTE, SRC_REG, 32'h0000_0123, 32'h10, 4'h0, 4'h0);
    ck_run(16, 4'h3, 1'b1, 1'b1);
    chk(ACC_OUT[7:0] === 8'h12 && RES_OUT[7:0] === 8'h03, "register divide result");
    // Memory form: CORR_B is added a second time only when the remainder goes back
    run_op(OP_UNSIGNED_DIVIDE_BYTE, SRC_MEM, 32'h0000_0123, 32'h0, 4'h2, 4'h3);
    ck_run(11, 4'h3, 1'b0, 1'b0);
    run_op(OP_UNSIGNED_DIVIDE_BYTE, SRC_MEM, 32'h0000_1000, 32'h02, 4'h2, 4'h3);
    ck_run(14, 4'h3, 1'b0, 1'b0);
    run_op(OP_UNSIGNED_DIVIDE_BYTE, SRC_MEM, 32'h0000_0123, 32'h10, 4'h2, 4'h3);
    ck_run(27, 4'h3, 1'b1, 1'b1);
  endtask : t_udiv_byte_ext

  task automatic t_udiv_word;
    run_op(OP_UNSIGNED_DIVIDE_WORD, SRC_REG, 32'h0001_0000, 32'h0, 4'h0, 4'h0);
    ck_run(4, 4'h3, 1'b0, 1'b0);
    run_op(OP_UNSIGNED_DIVIDE_WORD, SRC_REG, 32'h0010_0000, 32'h1, 4'h0, 4'h0);
    ck_run(7, 4'h3, 1'b0, 1'b0);
    run_op(OP_UNSIGNED_DIVIDE_WORD, SRC_REG, 32'h0001_0005, 32'h10, 4'h0, 4'h0);
    ck_run(22, 4'h3, 1'b1, 1'b1);
    chk(ACC_OUT[15:0] === 16'h1000 && RES_OUT[15:0] === 16'h0005, "word divide result");
    run_op(OP_UNSIGNED_DIVIDE_WORD, SRC_MEM, 32'h0001_0000, 32'h0, 4'h1, 4'h2);
    ck_run(9, 4'h3, 1'b0, 1'b0);
    run_op(OP_UNSIGNED_DIVIDE_WORD, SRC_MEM, 32'h0010_0000, 32'h1, 4'h1, 4'h2);
    ck_run(11, 4'h3, 1'b0, 1'b0);
    run_op(OP_UNSIGNED_DIVIDE_WORD, SRC_MEM, 32'h0001_0005, 32'h10, 4'h1, 4'h2);
    ck_run(31, 4'h3, 1'b1, 1'b1);
  endtask : t_udiv_word

  task automatic t_sdiv;
    // Exact quotients keep the remainder sign convention out of the check
    run_op(OP_SIGNED_DIVIDE_BYTE, SRC_REG, 32'h0000_fff0, 32'h04, 4'h0, 4'h0);
    chk(ACC_OUT[7:0] === 8'hfc && RES_OUT[7:0] === 8'h00, "signed byte divide");
    chk(ACC_WE === 1'b1 && RES_WE === 1'b1 && FLAGS[1:0] === 2'b00, "signed byte writes");
    run_op(OP_SIGNED_DIVIDE_WORD, SRC_REG, 32'hffff_fff0, 32'h0004, 4'h0, 4'h0);
    chk(ACC_OUT[15:0] === 16'hfffc && RES_OUT[15:0] === 16'h0000, "signed word divide");
    run_op(OP_SIGNED_DIVIDE_BYTE, SRC_REG, 32'h0000_7fff, 32'h01, 4'h0, 4'h0);
    chk(ACC_WE === 1'b0 && FLAGS[1:0] === 2'b10, "signed overflow");
  endtask : t_sdiv

  task automatic mul_case(input mdp_op_t op, input mdp_src_t src, input logic [31:0] acc,
                          input logic [31:0] opnd, input int n, input logic [31:0] prod);
    run_op(op, src, acc, opnd, 4'h1, 4'h2);
    ck_run(n, 4'h0, 1'b1, 1'b0);
    chk((op == OP_UNSIGNED_MULTIPLY_BYTE) ? ACC_OUT[15:0] === prod[15:0] : ACC_OUT === prod,
        "product");
  endtask : mul_case

  task automatic t_mul;
    mul_case(OP_UNSIGNED_MULTIPLY_BYTE, SRC_ACC, 32'h0000_0010, 32'h0, 3, 32'h0);
    mul_case(OP_UNSIGNED_MULTIPLY_BYTE, SRC_ACC, 32'h0012_0010, 32'h0, 7, 32'h0120);
    mul_case(OP_UNSIGNED_MULTIPLY_BYTE, SRC_REG, 32'h10, 32'h00, 4, 32'h0);
    mul_case(OP_UNSIGNED_MULTIPLY_BYTE, SRC_REG, 32'h10, 32'h12, 8, 32'h0120);
    mul_case(OP_UNSIGNED_MULTIPLY_BYTE, SRC_MEM, 32'h10, 32'h00, 8, 32'h0);
    mul_case(OP_UNSIGNED_MULTIPLY_BYTE, SRC_MEM, 32'h10, 32'hff, 12, 32'h0ff0);
    mul_case(OP_UNSIGNED_MULTIPLY_WORD, SRC_ACC, 32'h0000_1234, 32'h0, 3, 32'h0);
    mul_case(OP_UNSIGNED_MULTIPLY_WORD, SRC_ACC, 32'hffff_ffff, 32'h0, 11, 32'hfffe_0001);
    mul_case(OP_UNSIGNED_MULTIPLY_WORD, SRC_REG, 32'h1234, 32'h0, 4, 32'h0);
    mul_case(OP_UNSIGNED_MULTIPLY_WORD, SRC_REG, 32'h1234, 32'h2, 12, 32'h2468);
    mul_case(OP_UNSIGNED_MULTIPLY_WORD, SRC_MEM, 32'h1234, 32'h0, 8, 32'h0);
    mul_case(OP_UNSIGNED_MULTIPLY_WORD, SRC_MEM, 32'h1234, 32'h2, 16, 32'h2468);
  endtask : t_mul

  task automatic cmp_case(input mdp_op_t op, input mdp_src_t src, input logic [31:0] acc,
                          input logic [31:0] opnd, input int n, input logic [3:0] f);
    run_op(op, src, acc, opnd, 4'h0, 4'h0);
    ck_run(n, 4'hf, 1'b0, 1'b0);
    chk(FLAGS === f, "compare flags");
  endtask : cmp_case

  task automatic t_cmp;
    cmp_case(OP_COMPARE_LONG, SRC_IMM, 32'h5, 32'h5, 3, 4'h4);
    cmp_case(OP_COMPARE_LONG, SRC_IMM, 32'h1, 32'h2, 3, 4'h9);
    cmp_case(OP_COMPARE_BYTE, SRC_REG, 32'h80, 32'h01, 2, 4'h2);
    cmp_case(OP_COMPARE_WORD, SRC_IMM, 32'h0, 32'h1, 2, 4'h9);
    cmp_case(OP_COMPARE_BYTE, SRC_ACC, 32'h0003_0003, 32'h0, 1, 4'h4);
    cmp_case(OP_COMPARE_WORD, SRC_MEM, 32'h2, 32'h1, 3, 4'h0);
    cmp_case(OP_COMPARE_LONG, SRC_REG, 32'h8000_0000, 32'h1, 6, 4'h2);
    cmp_case(OP_COMPARE_LONG, SRC_MEM, 32'h0, 32'h8000_0000, 7, 4'hb);
  endtask : t_cmp

  // Clock enable freezes the count; a request while busy is dropped
  task automatic t_ce_refuse;
    @(posedge CLK);
    OP      <= OP_COMPARE_LONG;
    SRC     <= SRC_IMM;
    ACC_IN  <= 32'h5;
    OPND_IN <= 32'h5;
    START   <= 1'b1;
    @(posedge CLK);
    START <= 1'b0;
    @(posedge CLK);
    OP    <= OP_UNSIGNED_MULTIPLY_WORD;
    SRC   <= SRC_ACC;
    START <= 1'b1;
    @(posedge CLK);
    START <= 1'b0;
    CE    <= 1'b0;
    repeat (2) @(posedge CLK);
    CE <= 1'b1;
    #1;
    chk(DONE === 1'b0 && BUSY === 1'b1, "frozen while disabled");
    @(posedge CLK);
    #1;
    chk(DONE === 1'b1 && FLAGS === 4'h4 && FLAG_WE === 4'hf, "paused compare");
    @(posedge CLK);
    #1;
    chk(BUSY === 1'b0 && DONE === 1'b0, "busy request dropped");
  endtask : t_ce_refuse

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    CLK = 1'b0; SYS_RST = 1'b1; CE = 1'b1; START = 1'b0; OP = OP_COMPARE_BYTE;
    SRC = SRC_ACC; ACC_IN = 32'h0; OPND_IN = 32'h0; CORR_A = 4'h0; CORR_B = 4'h0;
    failures = 0; tests_run = 0; cyc = 0;
    repeat (4) @(posedge CLK);
    SYS_RST <= 1'b0;
    #1;
    chk(BUSY === 1'b0 && DONE === 1'b0 && FLAG_WE === 4'h0, "reset outputs");
    t_udiv_byte_acc();
    t_udiv_byte_ext();
    t_udiv_word();
    t_sdiv();
    t_mul();
    t_cmp();
    t_ce_refuse();
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
